//--- pkg/hic_pkg.sv
// Constants shared by the host interrupt control and pin monitor block
package hic_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W             = 4;
  localparam int          DATA_W             = 8;
  localparam logic [3:0]  OFFS_IRQ_CONTROL   = 4'h0;
  localparam logic [3:0]  OFFS_PIN_MONITOR   = 4'h1;
  localparam logic [7:0]  UNMAPPED_READ      = 8'h00;

  // ---------------------------------------------------------------------------
  // Interrupt control register fields
  // ---------------------------------------------------------------------------
  localparam int          BIT_GATE_A20       = 7;
  localparam int          BIT_BUS_RESET      = 6;
  localparam int          BIT_SHUTDOWN_REQ   = 5;
  localparam int          BIT_CYCLE_ABORT    = 4;
  localparam int          BIT_CH3_RX_EN      = 3;
  localparam int          BIT_CH2_RX_EN      = 2;
  localparam int          BIT_CH1_RX_EN      = 1;
  localparam int          BIT_ERROR_EN       = 0;
  localparam logic        FLAG_RESET         = 1'b0;
  localparam logic [3:0]  ENABLE_RESET       = 4'h0;

  // ---------------------------------------------------------------------------
  // Pin monitor register fields
  // ---------------------------------------------------------------------------
  localparam int          BIT_MON_FRAME      = 7;
  localparam int          BIT_MON_CLKRUN     = 6;
  localparam int          BIT_MON_SERIRQ     = 5;
  localparam int          BIT_MON_LRESET     = 4;
  localparam int          BIT_MON_LPCPD      = 3;
  localparam int          BIT_MON_PME        = 2;
  localparam int          BIT_MON_SMI        = 1;
  localparam int          BIT_MON_SCI        = 0;

  // ---------------------------------------------------------------------------
  // Synchroniser reset values (pins idle high)
  // ---------------------------------------------------------------------------
  localparam logic [8:0]  PIN_SYNC_RESET     = 9'h1ff;
  localparam logic        FRAME_IDLE         = 1'b1;
  localparam logic        TOGGLE_RESET       = 1'b0;

endpackage

//--- hw/hic_irq_pin_monitor.sv
// Host interface interrupt control, error flags and pin monitor
//
// What this block does
// - Read-only monitor bits: gate A20 in control bit 7, eight host pins in monitor.
// - Monitor bits follow the pins always, regardless of interface state or muxing.
// - Falling edge on bus reset pin sets bus reset flag, an error source.
// - Bus reset flag clears only by writing 0 after reading 1.
// - Falling edge on power-down pin sets shutdown request flag, an error source.
// - Shutdown request flag clears by 0-after-1 write or hardware/software LPC reset.
// - Frame falling during a transfer cycle sets cycle abort flag, an error source.
// - Abort flag clears by 0-after-1 write, LPC reset, or LPC shutdown.
// - Error interrupt is any flag set, gated by the error interrupt enable.
// - Channel 3 enable gates input 3 and, with bidir enable, bidir receive.
// - Channel 2 receive interrupt forwarded only while its enable is 1.
// - Channel 1 receive interrupt forwarded only while its enable is 1.
// - Flags and enables readable by local processor only, all reset to 0.
`timescale 1ns/100ps
`default_nettype none

module hic_irq_pin_monitor (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // Link clock domain
  input  wire logic                       linkClk,
  input  wire logic                       linkFrameN,
  input  wire logic                       linkCycleBusy,
  // Register port
  input  wire logic [hic_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [hic_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [hic_pkg::DATA_W-1:0] regRdata,
  // Monitored pins, asynchronous to clk
  input  wire logic                       gateA20Pin,
  input  wire logic                       frameNPin,
  input  wire logic                       clkrunNPin,
  input  wire logic                       serirqPin,
  input  wire logic                       lresetNPin,
  input  wire logic                       lpcpdNPin,
  input  wire logic                       pmeNPin,
  input  wire logic                       smiOutputPin,
  input  wire logic                       sciOutputPin,
  // Interface state from neighbouring logic on clk
  input  wire logic                       lpcSwReset,
  input  wire logic                       lpcHwShutdown,
  input  wire logic                       lpcSwShutdown,
  input  wire logic                       ch1RxDone,
  input  wire logic                       ch2RxDone,
  input  wire logic                       ch3RxDone,
  input  wire logic                       bidirRxDone,
  input  wire logic                       bidirIrqEnable,
  // Interrupt requests to the local processor
  output logic                            errorIrq,
  output logic                            ch1RxIrq,
  output logic                            ch2RxIrq,
  output logic                            ch3RxIrq
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [8:0] pinRaw;
  logic [8:0] pinMeta;
  logic [8:0] pinSync;
  logic [8:0] pinPrev;
  logic [8:0] next_pinMeta;
  logic [8:0] next_pinSync;
  logic [8:0] next_pinPrev;

  // Bundle the pins; low eight line up with the monitor register layout
  assign pinRaw = {gateA20Pin, frameNPin, clkrunNPin, serirqPin, lresetNPin,
                   lpcpdNPin, pmeNPin, smiOutputPin, sciOutputPin};

  // First stage feeds only the second; edge history comes from the second
  always_comb begin
    next_pinMeta = pinRaw;
    next_pinSync = pinMeta;
    next_pinPrev = pinSync;
  end

  // Synchroniser registers; pins idle high out of reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta <= hic_pkg::PIN_SYNC_RESET;
      pinSync <= hic_pkg::PIN_SYNC_RESET;
      pinPrev <= hic_pkg::PIN_SYNC_RESET;
    end else begin
      pinMeta <= next_pinMeta;
      pinSync <= next_pinSync;
      pinPrev <= next_pinPrev;
    end
  end

  logic       gateA20Mon;
  logic [7:0] pinMonitor;
  logic       lresetFall;
  logic       lpcpdFall;
  logic       lpcHwReset;

  // Monitor bits run free of every enable, reset or shutdown state
  assign gateA20Mon = pinSync[8];
  assign pinMonitor = pinSync[7:0];

  // Edges and levels taken from the synchronised copies only
  assign lresetFall = pinPrev[hic_pkg::BIT_MON_LRESET]
                    & ~pinSync[hic_pkg::BIT_MON_LRESET];
  assign lpcpdFall  = pinPrev[hic_pkg::BIT_MON_LPCPD]
                    & ~pinSync[hic_pkg::BIT_MON_LPCPD];
  assign lpcHwReset = ~pinSync[hic_pkg::BIT_MON_LRESET];

  // ---------------------------------------------------------------------------
  // Link domain: abort detection
  // ---------------------------------------------------------------------------
  // Frame is sampled on the link clock, where it is synchronous; an abort
  // is a frame fall while the cycle logic still reports a transfer.
  logic linkFramePrev;
  logic linkAbortToggle;
  logic next_linkFramePrev;
  logic next_linkAbortToggle;

  // Each abort flips the toggle once so no event is lost across domains
  always_comb begin
    next_linkFramePrev   = linkFrameN;
    next_linkAbortToggle = linkAbortToggle;
    if (linkFramePrev && !linkFrameN && linkCycleBusy) begin
      next_linkAbortToggle = ~linkAbortToggle;
    end
  end

  // Link clock may stop between frames; state simply holds meanwhile
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      linkFramePrev   <= hic_pkg::FRAME_IDLE;
      linkAbortToggle <= hic_pkg::TOGGLE_RESET;
    end else begin
      linkFramePrev   <= next_linkFramePrev;
      linkAbortToggle <= next_linkAbortToggle;
    end
  end

  // ---------------------------------------------------------------------------
  // Abort toggle crossing into clk
  // ---------------------------------------------------------------------------
  logic abortMeta;
  logic abortSync;
  logic abortSeen;
  logic next_abortMeta;
  logic next_abortSync;
  logic next_abortSeen;
  logic abortEvent;

  // Two flops, then a third to find the change of level
  always_comb begin
    next_abortMeta = linkAbortToggle;
    next_abortSync = abortMeta;
    next_abortSeen = abortSync;
  end

  // Toggle synchroniser registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      abortMeta <= hic_pkg::TOGGLE_RESET;
      abortSync <= hic_pkg::TOGGLE_RESET;
      abortSeen <= hic_pkg::TOGGLE_RESET;
    end else begin
      abortMeta <= next_abortMeta;
      abortSync <= next_abortSync;
      abortSeen <= next_abortSeen;
    end
  end

  // One clk pulse per abort seen on the link
  assign abortEvent = abortSync ^ abortSeen;

  // ---------------------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------------------
  logic ctrlWrite;
  logic ctrlRead;

  assign ctrlWrite = regWrite && (regAddr == hic_pkg::OFFS_IRQ_CONTROL);
  assign ctrlRead  = regRead  && (regAddr == hic_pkg::OFFS_IRQ_CONTROL);

  // ---------------------------------------------------------------------------
  // Error flags, read-armed markers and enables
  // ---------------------------------------------------------------------------
  // A write clears a flag only when it was read as 1 earlier; the armed bit remembers
  // that read. Hardware set beats a software clear in the same cycle.
  logic       busResetFlag;
  logic       shutdownReqFlag;
  logic       cycleAbortFlag;
  logic [2:0] flagArmed;
  logic       ch3RxIrqEnable;
  logic       ch2RxIrqEnable;
  logic       ch1RxIrqEnable;
  logic       errorIrqEnable;

  logic       next_busResetFlag;
  logic       next_shutdownReqFlag;
  logic       next_cycleAbortFlag;
  logic [2:0] next_flagArmed;
  logic       next_ch3RxIrqEnable;
  logic       next_ch2RxIrqEnable;
  logic       next_ch1RxIrqEnable;
  logic       next_errorIrqEnable;

  logic [2:0] flagsNow;
  logic [2:0] swClear;
  logic       lpcReset;
  logic       lpcShutdown;

  assign flagsNow    = {busResetFlag, shutdownReqFlag, cycleAbortFlag};
  assign lpcReset    = lpcHwReset | lpcSwReset;
  assign lpcShutdown = lpcHwShutdown | lpcSwShutdown;

  // Written 0 on an armed, set flag; a 1 in the data leaves the flag alone
  assign swClear = {3{ctrlWrite}} & flagArmed & flagsNow
                 & ~regWdata[hic_pkg::BIT_BUS_RESET:hic_pkg::BIT_CYCLE_ABORT];

  // Next values of flags and enables
  always_comb begin
    next_busResetFlag    = busResetFlag;
    next_shutdownReqFlag = shutdownReqFlag;
    next_cycleAbortFlag  = cycleAbortFlag;
    next_flagArmed       = flagArmed;
    next_ch3RxIrqEnable  = ch3RxIrqEnable;
    next_ch2RxIrqEnable  = ch2RxIrqEnable;
    next_ch1RxIrqEnable  = ch1RxIrqEnable;
    next_errorIrqEnable  = errorIrqEnable;

    // Reading a flag as 1 arms its clear
    if (ctrlRead) begin
      next_flagArmed = flagArmed | flagsNow;
    end

    // Bus reset flag: only a software clear lowers it
    if (swClear[2]) begin
      next_busResetFlag = 1'b0;
    end
    if (lresetFall) begin
      next_busResetFlag = 1'b1;
    end

    // Shutdown request flag: interface reset outranks a new request
    if (swClear[1]) begin
      next_shutdownReqFlag = 1'b0;
    end
    if (lpcpdFall) begin
      next_shutdownReqFlag = 1'b1;
    end
    if (lpcReset) begin
      next_shutdownReqFlag = 1'b0;
    end

    // Cycle abort flag: reset or shutdown holds it low
    if (swClear[0]) begin
      next_cycleAbortFlag = 1'b0;
    end
    if (abortEvent) begin
      next_cycleAbortFlag = 1'b1;
    end
    if (lpcReset || lpcShutdown) begin
      next_cycleAbortFlag = 1'b0;
    end

    // A flag that reads 0 cannot stay armed
    next_flagArmed = next_flagArmed
                   & {next_busResetFlag, next_shutdownReqFlag, next_cycleAbortFlag};

    // Enables are plain read/write bits
    if (ctrlWrite) begin
      next_ch3RxIrqEnable = regWdata[hic_pkg::BIT_CH3_RX_EN];
      next_ch2RxIrqEnable = regWdata[hic_pkg::BIT_CH2_RX_EN];
      next_ch1RxIrqEnable = regWdata[hic_pkg::BIT_CH1_RX_EN];
      next_errorIrqEnable = regWdata[hic_pkg::BIT_ERROR_EN];
    end
  end

  // Flag and enable registers, all clear out of reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busResetFlag    <= hic_pkg::FLAG_RESET;
      shutdownReqFlag <= hic_pkg::FLAG_RESET;
      cycleAbortFlag  <= hic_pkg::FLAG_RESET;
      flagArmed       <= 3'h0;
      {ch3RxIrqEnable, ch2RxIrqEnable, ch1RxIrqEnable, errorIrqEnable}
                      <= hic_pkg::ENABLE_RESET;
    end else begin
      busResetFlag    <= next_busResetFlag;
      shutdownReqFlag <= next_shutdownReqFlag;
      cycleAbortFlag  <= next_cycleAbortFlag;
      flagArmed       <= next_flagArmed;
      ch3RxIrqEnable  <= next_ch3RxIrqEnable;
      ch2RxIrqEnable  <= next_ch2RxIrqEnable;
      ch1RxIrqEnable  <= next_ch1RxIrqEnable;
      errorIrqEnable  <= next_errorIrqEnable;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt requests
  // ---------------------------------------------------------------------------
  logic next_errorIrq;
  logic next_ch1RxIrq;
  logic next_ch2RxIrq;
  logic next_ch3RxIrq;

  // Registered so the processor sees glitch-free levels, one cycle late
  always_comb begin
    next_errorIrq = errorIrqEnable & (|flagsNow);
    next_ch1RxIrq = ch1RxIrqEnable & ch1RxDone;
    next_ch2RxIrq = ch2RxIrqEnable & ch2RxDone;
    next_ch3RxIrq = ch3RxIrqEnable
                  & (ch3RxDone | (bidirIrqEnable & bidirRxDone));
  end

  // Interrupt output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      errorIrq <= 1'b0;
      ch1RxIrq <= 1'b0;
      ch2RxIrq <= 1'b0;
      ch3RxIrq <= 1'b0;
    end else begin
      errorIrq <= next_errorIrq;
      ch1RxIrq <= next_ch1RxIrq;
      ch2RxIrq <= next_ch2RxIrq;
      ch3RxIrq <= next_ch3RxIrq;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [7:0] next_regRdata;

  // Both registers live on the local side only; the host has no path here
  always_comb begin
    next_regRdata = hic_pkg::UNMAPPED_READ;
    if (regRead) begin
      if (regAddr == hic_pkg::OFFS_IRQ_CONTROL) begin
        next_regRdata = {gateA20Mon, busResetFlag, shutdownReqFlag, cycleAbortFlag,
                         ch3RxIrqEnable, ch2RxIrqEnable, ch1RxIrqEnable,
                         errorIrqEnable};
      end else if (regAddr == hic_pkg::OFFS_PIN_MONITOR) begin
        next_regRdata = pinMonitor;
      end
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= hic_pkg::UNMAPPED_READ;
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule

`default_nettype wire

//--- sim/hic_irq_pin_monitor_assertions.sv
// Checker for the interrupt control and pin monitor ports
`timescale 1ns/100ps
`default_nettype none

module hic_irq_pin_monitor_checker (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       gateA20Pin,
  input wire logic       frameNPin,
  input wire logic       clkrunNPin,
  input wire logic       serirqPin,
  input wire logic       lresetNPin,
  input wire logic       lpcpdNPin,
  input wire logic       pmeNPin,
  input wire logic       smiOutputPin,
  input wire logic       sciOutputPin,
  input wire logic       ch1RxDone,
  input wire logic       ch2RxDone,
  input wire logic       ch3RxDone,
  input wire logic       bidirRxDone,
  input wire logic       bidirIrqEnable,
  input wire logic       errorIrq,
  input wire logic       ch1RxIrq,
  input wire logic       ch2RxIrq,
  input wire logic       ch3RxIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Shadow of the enables, as software last wrote them
  // ----------------------------------------------------------------
  logic [3:0] en;
  logic [3:0] next_en;
  wire logic  ch1Want = en[1] && ch1RxDone;
  wire logic  ch2Want = en[2] && ch2RxDone;
  wire logic  ch3Want = en[3] && (ch3RxDone || (bidirIrqEnable && bidirRxDone));
  wire logic [7:0] pinVec = {frameNPin, clkrunNPin, serirqPin, lresetNPin,
                             lpcpdNPin, pmeNPin, smiOutputPin, sciOutputPin};

  // Next enables on a control register write
  always_comb begin
    next_en = en;
    if (regWrite && regAddr == hic_pkg::OFFS_IRQ_CONTROL) begin
      next_en = regWdata[3:0];
    end
  end

  // Enables register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en <= hic_pkg::ENABLE_RESET;
    end else begin
      en <= next_en;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_rd(a);
    regRead && regAddr == a;
  endsequence
  // Four quiet cycles cover the two synchroniser flops with margin
  sequence s_steady;
    $stable(pinVec) && $stable(gateA20Pin);
  endsequence

  property p_idle;
    !$past(regRead) |-> regRdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_mon;
    s_steady [*4] ##0 s_rd(hic_pkg::OFFS_PIN_MONITOR) |=> regRdata == $past(pinVec);
  endproperty
  a_mon: assert property (p_mon) else $error("pin monitor wrong");
  property p_a20;
    s_steady [*4] ##0 s_rd(hic_pkg::OFFS_IRQ_CONTROL) |=> regRdata[7] == $past(gateA20Pin);
  endproperty
  a_a20: assert property (p_a20) else $error("gate monitor wrong");
  property p_rst;
    $fell(lresetNPin) && en[0] |-> ##[3:5] errorIrq;
  endproperty
  a_rst: assert property (p_rst) else $error("bus reset edge lost");
  property p_pd;
    $fell(lpcpdNPin) && en[0] && lresetNPin |-> ##[3:5] errorIrq;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down edge lost");
  property p_mask;
    !$past(en[0]) |-> !errorIrq;
  endproperty
  a_mask: assert property (p_mask) else $error("error irq not masked");
  property p_ch1;
    ch1RxIrq == $past(ch1Want);
  endproperty
  a_ch1: assert property (p_ch1) else $error("channel 1 irq wrong");
  property p_ch2;
    ch2RxIrq == $past(ch2Want);
  endproperty
  a_ch2: assert property (p_ch2) else $error("channel 2 irq wrong");
  property p_ch3;
    ch3RxIrq == $past(ch3Want);
  endproperty
  a_ch3: assert property (p_ch3) else $error("channel 3 irq wrong");
endmodule

`default_nettype wire

//--- sim/hic_lpc_host_model.sv
// Behavioural host on the link: clock and frame line
`timescale 1ns/100ps
`default_nettype none

module hic_lpc_host_model (
  output logic linkClk,
  output logic linkFrameN,
  output logic linkCycleBusy
);
  // Idle link: clock stopped, frame released high
  initial begin
    linkClk = 1'b0;
    linkFrameN = 1'b1;
    linkCycleBusy = 1'b0;
  end

  // Link clock runs only inside frames, 15 ns period
  task automatic tick(input int n);
    repeat (n) begin
      #7.5 linkClk = 1'b1;
      #7.5 linkClk = 1'b0;
    end
  endtask

  // Frame cut short by dropping frame again, changes after falling edges
  task automatic frameAbort(input logic busy);
    tick(2);
    linkCycleBusy = busy;
    tick(2);
    linkFrameN = 1'b0;
    tick(3);
    linkFrameN = 1'b1;
    linkCycleBusy = 1'b0;
    tick(2);
  endtask
endmodule

`default_nettype wire

//--- sim/test_hic_irq_pin_monitor.sv
// Self-checking bench for the interrupt control and pin monitor block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin nErrors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module test_hic_irq_pin_monitor;
  localparam logic [3:0] CTL = hic_pkg::OFFS_IRQ_CONTROL;
  localparam logic [3:0] MON = hic_pkg::OFFS_PIN_MONITOR;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [7:0] regRdata;
  logic       gateA20Pin = 1'b1;
  logic [6:0] pins = 7'h7f;
  logic       lpcSwReset = 1'b0;
  logic       lpcHwShutdown = 1'b0;
  logic       lpcSwShutdown = 1'b0;
  logic [3:0] done = 4'h0;
  logic       bidirIrqEnable = 1'b0;
  logic       errorIrq;
  logic       ch1RxIrq;
  logic       ch2RxIrq;
  logic       ch3RxIrq;
  wire logic  linkClk;
  wire logic  linkFrameN;
  wire logic  linkCycleBusy;
  int         nErrors = 0;
  int         checked = 0;
  int         cycles = 0;

  // ----------------------------------------------------------------
  // Clock, watchdog and instances
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end

  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      closeOut();
    end
  end

  hic_lpc_host_model host (.linkClk(linkClk), .linkFrameN(linkFrameN),
    .linkCycleBusy(linkCycleBusy));

  hic_irq_pin_monitor DUT (.clk(clk), .arst_n(arst_n), .linkClk(linkClk),
    .linkFrameN(linkFrameN), .linkCycleBusy(linkCycleBusy), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .gateA20Pin(gateA20Pin), .frameNPin(linkFrameN), .clkrunNPin(pins[6]),
    .serirqPin(pins[5]), .lresetNPin(pins[4]), .lpcpdNPin(pins[3]), .pmeNPin(pins[2]),
    .smiOutputPin(pins[1]), .sciOutputPin(pins[0]), .lpcSwReset(lpcSwReset),
    .lpcHwShutdown(lpcHwShutdown), .lpcSwShutdown(lpcSwShutdown),
    .ch1RxDone(done[0]), .ch2RxDone(done[1]), .ch3RxDone(done[2]),
    .bidirRxDone(done[3]), .bidirIrqEnable(bidirIrqEnable), .errorIrq(errorIrq),
    .ch1RxIrq(ch1RxIrq), .ch2RxIrq(ch2RxIrq), .ch3RxIrq(ch3RxIrq));

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    `CHK("regRdata", e, regRdata)
  endtask

  // Expected order: ch3, ch2, ch1, error
  task automatic irqs(input logic [3:0] e);
    #1;
    `CHK("irqs", e, {ch3RxIrq, ch2RxIrq, ch1RxIrq, errorIrq})
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tMonitor();
    @(posedge clk);
    pins <= 7'h5a;
    gateA20Pin <= 1'b0;
    lpcSwShutdown <= 1'b1;
    cyc(4);
    rdc(MON, 8'hda);
    rdc(CTL, 8'h00);
    wr(MON, 8'h0f);
    rdc(CTL, 8'h00);
    @(posedge clk);
    pins <= 7'h18;
    cyc(4);
    rdc(MON, 8'h98);
    @(posedge clk);
    pins <= 7'h7f;
    gateA20Pin <= 1'b1;
    lpcSwShutdown <= 1'b0;
    cyc(4);
  endtask

  task automatic tChannels();
    @(posedge clk);
    done <= 4'h7;
    for (int m = 0; m < 8; m++) begin
      wr(CTL, {4'h0, 3'(m), 1'b0});
      cyc(1);
      irqs({3'(m), 1'b0});
    end
    @(posedge clk);
    done <= 4'h8;
    wr(CTL, 8'h08);
    cyc(1);
    irqs(4'h0);
    @(posedge clk);
    bidirIrqEnable <= 1'b1;
    cyc(2);
    irqs(4'h8);
    wr(CTL, 8'h00);
    cyc(1);
    irqs(4'h0);
  endtask

  task automatic tBusReset();
    wr(CTL, 8'h01);
    @(posedge clk);
    pins[4] <= 1'b0;
    cyc(3);
    pins[4] <= 1'b1;
    cyc(4);
    irqs(4'h1);
    wr(CTL, 8'h00);
    cyc(1);
    irqs(4'h0);
    wr(CTL, 8'h01);
    cyc(1);
    irqs(4'h1);
    rdc(CTL, 8'hc1);
    wr(CTL, 8'h01);
    rdc(CTL, 8'h81);
    wr(CTL, 8'h71);
    rdc(CTL, 8'h81);
  endtask

  // Power-down edge, then cleared by a software link reset
  task automatic tShutdown();
    @(posedge clk);
    pins[3] <= 1'b0;
    cyc(5);
    rdc(CTL, 8'ha1);
    irqs(4'h1);
    @(posedge clk);
    pins[3] <= 1'b1;
    lpcSwReset <= 1'b1;
    @(posedge clk);
    lpcSwReset <= 1'b0;
    rdc(CTL, 8'h81);
    // New request, then a bus reset pin low clears it
    @(posedge clk);
    pins[3] <= 1'b0;
    cyc(5);
    pins[4] <= 1'b0;
    cyc(4);
    pins[4] <= 1'b1;
    pins[3] <= 1'b1;
    cyc(4);
    rdc(CTL, 8'hc1);
    wr(CTL, 8'h01);
    rdc(CTL, 8'h81);
  endtask

  // Abort without a cycle in flight must be ignored
  task automatic tAbort();
    host.frameAbort(1'b0);
    cyc(6);
    rdc(CTL, 8'h81);
    host.frameAbort(1'b1);
    cyc(6);
    rdc(CTL, 8'h91);
    irqs(4'h1);
    @(posedge clk);
    lpcHwShutdown <= 1'b1;
    @(posedge clk);
    lpcHwShutdown <= 1'b0;
    rdc(CTL, 8'h81);
    host.frameAbort(1'b1);
    cyc(6);
    rdc(CTL, 8'h91);
    @(posedge clk);
    lpcSwShutdown <= 1'b1;
    @(posedge clk);
    lpcSwShutdown <= 1'b0;
    rdc(CTL, 8'h81);
    host.frameAbort(1'b1);
    cyc(6);
    rdc(CTL, 8'h91);
    @(posedge clk);
    lpcSwReset <= 1'b1;
    @(posedge clk);
    lpcSwReset <= 1'b0;
    rdc(CTL, 8'h81);
  endtask

  task automatic closeOut();
    if (nErrors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdc(CTL, 8'h80);
    rdc(4'h5, hic_pkg::UNMAPPED_READ);
    irqs(4'h0);
    tMonitor();
    tChannels();
    tBusReset();
    tShutdown();
    tAbort();
    closeOut();
  end
endmodule

bind hic_irq_pin_monitor hic_irq_pin_monitor_checker u_chk (.clk(clk), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .gateA20Pin(gateA20Pin), .frameNPin(frameNPin),
  .clkrunNPin(clkrunNPin), .serirqPin(serirqPin), .lresetNPin(lresetNPin),
  .lpcpdNPin(lpcpdNPin), .pmeNPin(pmeNPin), .smiOutputPin(smiOutputPin),
  .sciOutputPin(sciOutputPin), .ch1RxDone(ch1RxDone), .ch2RxDone(ch2RxDone),
  .ch3RxDone(ch3RxDone), .bidirRxDone(bidirRxDone), .bidirIrqEnable(bidirIrqEnable),
  .errorIrq(errorIrq), .ch1RxIrq(ch1RxIrq), .ch2RxIrq(ch2RxIrq), .ch3RxIrq(ch3RxIrq));

`default_nettype wire
